// *** logic/cgc_pkg.sv ***
// Constants, types and register map of the compressor gain control block
// What this block does
// - Bits 3:2 of power/mode register pick dual, single, fixed stepped or fixed immediate.
// - Automatic modes: fast counter steps down at attack rate while above upper threshold.
// - Automatic modes: fast counter steps up below lower threshold, never above maximum gain.
// - Automatic modes: gain rises only after hold time below lower threshold; bit 4 picks 50 or 25 ms.
// - Dual mode: slow counter steps at slow rates toward the fast counter.
// - Dual mode: applied gain is the smaller of fast and slow counters.
// - Dual mode: fast rates from fast rate register, slow rates from slow rate register.
// - Single mode: slow counter copies fast counter, gain follows fast counter at fast rates.
// - Fixed stepped mode: gain steps toward gain register target regardless of signal.
// - Fixed immediate mode: gain jumps straight to the gain register target.
// - Gain register bit 7 set makes its reads return the applied gain.
// - Each step moves gain by one 0.5 dB code, passing every intermediate code.
// - Fixed stepped mode moves gain at 80 kdB per second.
// - Step rates come from selected divisions of a 1.28 MHz system tick.
// - Gain codes stay within -1 dB to 40 dB.
package cgc_pkg;

	// Clocking
	localparam int CLK_HZ        = 50_000_000;
	localparam int SYS_HZ        = 1_280_000;
	localparam int FRAC_INC      = SYS_HZ / 10_000;
	localparam int FRAC_MOD      = CLK_HZ / 10_000;

	// Gain code: 0 is -1 dB, each code 0.5 dB, top code 40 dB
	localparam int GAIN_W        = 7;
	localparam int GAIN_STEP_MDB = 500;
	localparam int GAIN_LOW_MDB  = -1000;
	localparam int GAIN_HIGH_MDB = 40_000;
	localparam logic [GAIN_W-1:0] GAIN_MAX_CODE =
		GAIN_W'((GAIN_HIGH_MDB - GAIN_LOW_MDB) / GAIN_STEP_MDB);

	// Step rate divider: period is (8 << select) system ticks
	localparam int RATE_SEL_W    = 3;
	localparam int RATE_BASE_LOG = 3;
	localparam int RATE_CNT_W    = RATE_BASE_LOG + (1 << RATE_SEL_W);
	localparam int FIXED_RATE_DBPS  = 80_000;
	localparam int FIXED_STEP_TICKS = SYS_HZ / (FIXED_RATE_DBPS / GAIN_STEP_MDB * 1000);
	localparam logic [RATE_SEL_W-1:0] FIXED_RATE_SEL =
		RATE_SEL_W'($clog2(FIXED_STEP_TICKS) - RATE_BASE_LOG);

	// Hold times below the lower threshold
	localparam int HOLD_LONG_MS  = 50;
	localparam int HOLD_SHORT_MS = 25;
	localparam int HOLD_LONG_CYC  = CLK_HZ / 1000 * HOLD_LONG_MS;
	localparam int HOLD_SHORT_CYC = CLK_HZ / 1000 * HOLD_SHORT_MS;
	localparam int HOLD_W        = 22;

	// Register byte offsets
	localparam logic [7:0] OFS_PWR_MODE  = 8'h00;
	localparam logic [7:0] OFS_FAST_RATE = 8'h04;
	localparam logic [7:0] OFS_SLOW_RATE = 8'h08;
	localparam logic [7:0] OFS_GAIN_SET  = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;

	// Field positions
	localparam int MODE_LSB      = 2;
	localparam int HOLD_SEL_BIT  = 4;
	localparam int ATK_LSB       = 0;
	localparam int REL_LSB       = 4;
	localparam int READ_MODE_BIT = 7;
	localparam int ST_FAST_LSB   = 8;
	localparam int ST_SLOW_LSB   = 16;
	localparam int ST_ABOVE_BIT  = 24;
	localparam int ST_BELOW_BIT  = 25;
	localparam int ST_HOLD_BIT   = 26;

	// Reset values
	localparam logic [7:0] PWR_MODE_RST  = 8'h00;
	localparam logic [7:0] FAST_RATE_RST = 8'h21;
	localparam logic [7:0] SLOW_RATE_RST = 8'h75;
	localparam logic [7:0] GAIN_SET_RST  = 8'h28;
	localparam logic [GAIN_W-1:0] GAIN_RST = 7'h00;

	typedef enum logic [1:0] {
		MODE_AUTO_DUAL,
		MODE_AUTO_SINGLE,
		MODE_FIXED_STEP,
		MODE_FIXED_NOW
	} cgc_mode_t;

endpackage : cgc_pkg

// *** logic/cgc_rate_gen.sv ***
// Step rate enables derived from a fractional 1.28 MHz system tick
`timescale 1ns/1ns
module cgc_rate_gen
	import cgc_pkg::*;
#(
	parameter int CHANNELS = 5
) (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 nrst,
	// Rate selects, one per channel
	input  wire logic [CHANNELS-1:0][RATE_SEL_W-1:0] rateSel,
	// One-cycle step enables
	output logic      [CHANNELS-1:0]                 stepEn
);

	////////////////////////////////////////////////////////////////////////////
	// 50 MHz is not a multiple of 1.28 MHz, so a fractional accumulator
	// gives the right average tick rate with a 20 ns jitter
	logic [12:0]           fracAcc_r, fracAcc_nxt;
	logic                  sysTick_r, sysTick_nxt;
	logic [RATE_CNT_W-1:0] tickCnt_r, tickCnt_nxt;
	logic [CHANNELS-1:0]   stepEn_nxt;

	function automatic logic rateHit(input logic [RATE_CNT_W-1:0] cnt,
	                                 input logic [RATE_SEL_W-1:0] sel);
		logic [RATE_CNT_W-1:0] mask;
		mask = (RATE_CNT_W'(1) << (sel + RATE_BASE_LOG)) - RATE_CNT_W'(1);
		return (cnt & mask) == mask;
	endfunction : rateHit

	always_comb begin
		if (fracAcc_r + 13'(FRAC_INC) >= 13'(FRAC_MOD)) begin
			fracAcc_nxt = fracAcc_r + 13'(FRAC_INC) - 13'(FRAC_MOD);
			sysTick_nxt = 1'b1;
		end else begin
			fracAcc_nxt = fracAcc_r + 13'(FRAC_INC);
			sysTick_nxt = 1'b0;
		end
		tickCnt_nxt = sysTick_r ? tickCnt_r + RATE_CNT_W'(1) : tickCnt_r;
	end

	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		assign stepEn_nxt[i] = sysTick_r && rateHit(tickCnt_r, rateSel[i]);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fracAcc_r <= 13'h0000;
			sysTick_r <= 1'b0;
			tickCnt_r <= '0;
			stepEn    <= '0;
		end else begin
			fracAcc_r <= fracAcc_nxt;
			sysTick_r <= sysTick_nxt;
			tickCnt_r <= tickCnt_nxt;
			stepEn    <= stepEn_nxt;
		end
	end

endmodule : cgc_rate_gen

// *** logic/cgc_top.sv ***
// Compressor gain control: APB registers, comparator sync, gain counters
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module cgc_top
	import cgc_pkg::*;
#(
	parameter int ADDR_W        = 8,
	parameter int HOLD_LONG     = HOLD_LONG_CYC,
	parameter int HOLD_SHORT    = HOLD_SHORT_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Peak comparators of the gain stage
	input  wire logic              aboveUpper,
	input  wire logic              belowLower,
	// Gain code to the input gain stage
	output logic      [GAIN_W-1:0] gainCode
);

	////////////////////////////////////////////////////////////////////////////
	// Registers and APB
	logic [7:0]  pwrMode_r, pwrMode_nxt;
	logic [7:0]  fastRate_r, fastRate_nxt;
	logic [7:0]  slowRate_r, slowRate_nxt;
	logic [7:0]  gainSet_r, gainSet_nxt;
	logic [31:0] prdata_nxt;
	logic        pready_nxt, pslverr_nxt;
	logic        wrAcc, setup;
	logic [7:0]  addrLo;
	logic        hit;
	logic [GAIN_W-1:0] fast_r, fast_nxt, slow_r, slow_nxt, gain_nxt;
	logic        aboveLvl_r, belowLvl_r, holdDone_r;
	cgc_mode_t   mode;
	logic [GAIN_W-1:0] target;

	function automatic logic [GAIN_W-1:0] clampGain(input logic [GAIN_W-1:0] g);
		return (g > GAIN_MAX_CODE) ? GAIN_MAX_CODE : g;
	endfunction : clampGain

	assign addrLo = 8'(paddr);
	assign setup  = psel && !penable;
	assign wrAcc  = psel && penable && pready && pwrite;
	assign hit    = addrLo == OFS_PWR_MODE || addrLo == OFS_FAST_RATE ||
	                addrLo == OFS_SLOW_RATE || addrLo == OFS_GAIN_SET ||
	                addrLo == OFS_STATUS;
	assign mode   = cgc_mode_t'(pwrMode_r[MODE_LSB +: 2]);
	assign target = clampGain(gainSet_r[GAIN_W-1:0]);

	always_comb begin
		pwrMode_nxt  = pwrMode_r;
		fastRate_nxt = fastRate_r;
		slowRate_nxt = slowRate_r;
		gainSet_nxt  = gainSet_r;
		// Answer one cycle after setup: a single access cycle per transfer
		pready_nxt   = setup;
		pslverr_nxt  = setup && !hit;
		prdata_nxt   = 32'h0000_0000;
		if (setup && !pwrite) begin
			case (addrLo)
				OFS_PWR_MODE:  prdata_nxt = {24'h000000, pwrMode_r};
				OFS_FAST_RATE: prdata_nxt = {24'h000000, fastRate_r};
				OFS_SLOW_RATE: prdata_nxt = {24'h000000, slowRate_r};
				OFS_GAIN_SET:  prdata_nxt = gainSet_r[READ_MODE_BIT] ?
				                            {25'h0000000, gainCode} :
				                            {24'h000000, gainSet_r};
				OFS_STATUS: begin
					prdata_nxt[GAIN_W-1:0]                = gainCode;
					prdata_nxt[ST_FAST_LSB +: GAIN_W]     = fast_r;
					prdata_nxt[ST_SLOW_LSB +: GAIN_W]     = slow_r;
					prdata_nxt[ST_ABOVE_BIT]              = aboveLvl_r;
					prdata_nxt[ST_BELOW_BIT]              = belowLvl_r;
					prdata_nxt[ST_HOLD_BIT]               = holdDone_r;
				end
				default:       prdata_nxt = 32'h0000_0000;
			endcase
		end
		if (wrAcc) begin
			case (addrLo)
				// Unused bits read back zero
				OFS_PWR_MODE:  pwrMode_nxt  = {3'h0, pwdata[4:2], 2'h0};
				OFS_FAST_RATE: fastRate_nxt = {1'h0, pwdata[6:4], 1'h0, pwdata[2:0]};
				OFS_SLOW_RATE: slowRate_nxt = {1'h0, pwdata[6:4], 1'h0, pwdata[2:0]};
				OFS_GAIN_SET:  gainSet_nxt  = {pwdata[READ_MODE_BIT],
				                               clampGain(pwdata[GAIN_W-1:0])};
				default:       pwrMode_nxt  = pwrMode_r;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwrMode_r  <= PWR_MODE_RST;
			fastRate_r <= FAST_RATE_RST;
			slowRate_r <= SLOW_RATE_RST;
			gainSet_r  <= GAIN_SET_RST;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			pwrMode_r  <= pwrMode_nxt;
			fastRate_r <= fastRate_nxt;
			slowRate_r <= slowRate_nxt;
			gainSet_r  <= gainSet_nxt;
			prdata     <= prdata_nxt;
			pready     <= pready_nxt;
			pslverr    <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparator sync and hold timer
	logic [2:0]        aboveSync_r, belowSync_r;
	logic [2:0]        aboveSync_nxt, belowSync_nxt;
	logic              aboveLvl_nxt, belowLvl_nxt, holdDone_nxt;
	logic [HOLD_W-1:0] holdCnt_r, holdCnt_nxt, holdLen;

	assign holdLen = pwrMode_r[HOLD_SEL_BIT] ? HOLD_W'(HOLD_SHORT) : HOLD_W'(HOLD_LONG);

	always_comb begin
		aboveSync_nxt = {aboveSync_r[1:0], aboveUpper};
		belowSync_nxt = {belowSync_r[1:0], belowLower};
		// Only stages 2 and 3 are compared; stage 1 may be metastable
		aboveLvl_nxt  = (aboveSync_r[1] == aboveSync_r[2]) ? aboveSync_r[2] : aboveLvl_r;
		belowLvl_nxt  = (belowSync_r[1] == belowSync_r[2]) ? belowSync_r[2] : belowLvl_r;
		holdCnt_nxt   = holdCnt_r;
		holdDone_nxt  = holdDone_r;
		if (!belowLvl_r || aboveLvl_r) begin
			holdCnt_nxt  = '0;
			holdDone_nxt = 1'b0;
		end else if (holdCnt_r >= holdLen - HOLD_W'(1)) begin
			holdDone_nxt = 1'b1;
		end else begin
			holdCnt_nxt  = holdCnt_r + HOLD_W'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aboveSync_r <= 3'h0;
			belowSync_r <= 3'h0;
			aboveLvl_r  <= 1'b0;
			belowLvl_r  <= 1'b0;
			holdCnt_r   <= '0;
			holdDone_r  <= 1'b0;
		end else begin
			aboveSync_r <= aboveSync_nxt;
			belowSync_r <= belowSync_nxt;
			aboveLvl_r  <= aboveLvl_nxt;
			belowLvl_r  <= belowLvl_nxt;
			holdCnt_r   <= holdCnt_nxt;
			holdDone_r  <= holdDone_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step rates and gain counters
	localparam int CH_FATK = 0;
	localparam int CH_FREL = 1;
	localparam int CH_SATK = 2;
	localparam int CH_SREL = 3;
	localparam int CH_FIX  = 4;

	logic [4:0][RATE_SEL_W-1:0] rateSel;
	logic [4:0]                 stepEn;

	assign rateSel[CH_FATK] = fastRate_r[ATK_LSB +: RATE_SEL_W];
	assign rateSel[CH_FREL] = fastRate_r[REL_LSB +: RATE_SEL_W];
	assign rateSel[CH_SATK] = slowRate_r[ATK_LSB +: RATE_SEL_W];
	assign rateSel[CH_SREL] = slowRate_r[REL_LSB +: RATE_SEL_W];
	assign rateSel[CH_FIX]  = FIXED_RATE_SEL;

	cgc_rate_gen #(
		.CHANNELS (5)
	) u_rate (
		.clk     (clk),
		.nrst    (nrst),
		.rateSel (rateSel),
		.stepEn  (stepEn)
	);

	always_comb begin
		fast_nxt = fast_r;
		slow_nxt = slow_r;
		gain_nxt = gainCode;
		case (mode)
			MODE_AUTO_DUAL, MODE_AUTO_SINGLE: begin
				// Single steps only, so every code is passed on the way
				if (fast_r > target) begin
					if (stepEn[CH_FATK]) fast_nxt = fast_r - GAIN_W'(1);
				end else if (aboveLvl_r) begin
					if (stepEn[CH_FATK] && fast_r != '0) fast_nxt = fast_r - GAIN_W'(1);
				end else if (holdDone_r && stepEn[CH_FREL] && fast_r < target) begin
					fast_nxt = fast_r + GAIN_W'(1);
				end
				if (mode == MODE_AUTO_DUAL) begin
					if (stepEn[CH_SATK] && slow_r > fast_r) slow_nxt = slow_r - GAIN_W'(1);
					else if (stepEn[CH_SREL] && slow_r < fast_r) slow_nxt = slow_r + GAIN_W'(1);
					gain_nxt = (fast_r < slow_r) ? fast_r : slow_r;
				end else begin
					slow_nxt = fast_r;
					gain_nxt = fast_r;
				end
			end
			MODE_FIXED_STEP: begin
				if (stepEn[CH_FIX] && gainCode > target) gain_nxt = gainCode - GAIN_W'(1);
				else if (stepEn[CH_FIX] && gainCode < target) gain_nxt = gainCode + GAIN_W'(1);
				fast_nxt = gainCode;
				slow_nxt = gainCode;
			end
			MODE_FIXED_NOW: begin
				gain_nxt = target;
				fast_nxt = gainCode;
				slow_nxt = gainCode;
			end
			default: gain_nxt = gainCode;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_r   <= GAIN_RST;
			slow_r   <= GAIN_RST;
			gainCode <= GAIN_RST;
		end else begin
			fast_r   <= fast_nxt;
			slow_r   <= slow_nxt;
			gainCode <= gain_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_gain_range;
		gainCode <= GAIN_MAX_CODE && fast_r <= GAIN_MAX_CODE;
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("gain code out of range");

	property p_single_step;
		!$stable(gainCode) && $past(mode) != MODE_FIXED_NOW && mode != MODE_FIXED_NOW
			|-> (gainCode == $past(gainCode) + 7'h01 || gainCode == $past(gainCode) - 7'h01);
	endproperty
	a_single_step: assert property (p_single_step) else $error("gain moved more than one step");

	property p_no_rise_in_hold;
		mode == MODE_AUTO_SINGLE && !holdDone_r ##1 mode == MODE_AUTO_SINGLE
			|-> fast_r <= $past(fast_r);
	endproperty
	a_no_rise_in_hold: assert property (p_no_rise_in_hold) else $error("gain rose before hold");

	property p_attack_down;
		mode == MODE_AUTO_SINGLE && aboveLvl_r && stepEn[CH_FATK] && fast_r != 7'h00
			|=> fast_r == $past(fast_r) - 7'h01;
	endproperty
	a_attack_down: assert property (p_attack_down) else $error("attack did not lower gain");

	property p_dual_min;
		mode == MODE_AUTO_DUAL ##1 mode == MODE_AUTO_DUAL
			|-> gainCode == (($past(fast_r) < $past(slow_r)) ? $past(fast_r) : $past(slow_r));
	endproperty
	a_dual_min: assert property (p_dual_min) else $error("dual gain is not the minimum");

	property p_immediate;
		mode == MODE_FIXED_NOW [*2] |-> gainCode == $past(target);
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate mode missed target");

	property p_hold_restart;
		aboveLvl_r || !belowLvl_r |=> holdCnt_r == '0 && !holdDone_r;
	endproperty
	a_hold_restart: assert property (p_hold_restart) else $error("hold timer not restarted");

	property p_read_gain;
		setup && !pwrite && addrLo == OFS_GAIN_SET && gainSet_r[READ_MODE_BIT]
			|=> pready && prdata == {25'h0000000, $past(gainCode)};
	endproperty
	a_read_gain: assert property (p_read_gain) else $error("gain read mode wrong");

	property p_fixed_rate;
		mode == MODE_FIXED_STEP && !stepEn[CH_FIX] ##1 mode == MODE_FIXED_STEP
			|-> $stable(gainCode);
	endproperty
	a_fixed_rate: assert property (p_fixed_rate) else $error("fixed step off its rate");

	c_attack:   cover property (mode == MODE_AUTO_DUAL && aboveLvl_r ##1 $fell(gainCode));
	c_release:  cover property (holdDone_r ##1 $rose(fast_r[0]));
	c_fixed:    cover property (mode == MODE_FIXED_STEP && gainCode != target ##1 $changed(gainCode));
	c_read_err: cover property (pready && pslverr);

endmodule : cgc_top

// *** verif/cgc_stage_model.sv ***
// Behavioural gain stage with its two peak comparators, levels in 0.5 dB units
`timescale 1ns/1ns
module cgc_stage_model
	import cgc_pkg::*;
#(
	parameter int UPPER_HDB = 100
) (
	// Applied gain from the block
	input  wire logic [GAIN_W-1:0] gainCode,
	// Input level set by the bench
	input  wire logic [7:0]        inLevel,
	// Comparator outputs, asynchronous
	output wire logic              aboveUpper,
	output wire logic              belowLower
);
	// Small settling delay keeps comparator edges off the clock edge
	assign #3 aboveUpper = (int'(inLevel) + int'(gainCode)) > UPPER_HDB;
	assign #3 belowLower = (int'(inLevel) + int'(gainCode)) < UPPER_HDB - 6;
endmodule : cgc_stage_model

// *** verif/testbench.sv ***
// Self-checking bench for the compressor gain control block
`timescale 1ns/1ns
module testbench
	import cgc_pkg::*;
;
	typedef struct {string nm; logic [31:0] val; logic [31:0] mask; logic err;} cgc_note_t;
	logic              clk, nrst, psel, penable, pwrite, stepWatch;
	logic [7:0]        paddr, inLevel;
	logic [31:0]       pwdata, prdata, t;
	logic              pready, pslverr, aboveUpper, belowLower;
	logic [GAIN_W-1:0] gainCode, prevGain;
	int                fails, checkCount, cyc;
	cgc_note_t         notes[$];
	cgc_note_t         cur;
	//////////////////////////////////////////////////////////////////////////
	// Short hold counts keep the run brief
	cgc_top #(.ADDR_W(8), .HOLD_LONG(2000), .HOLD_SHORT(1000)) DUT (.clk(clk), .nrst(nrst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .aboveUpper(aboveUpper),
		.belowLower(belowLower), .gainCode(gainCode));
	cgc_stage_model #(.UPPER_HDB(100)) stage (.gainCode(gainCode), .inLevel(inLevel),
		.aboveUpper(aboveUpper), .belowLower(belowLower));
	always #10 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task wrap_up;
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task apb(input logic [7:0] a, input logic wr, input logic [31:0] d, input cgc_note_t n);
		int w;
		w = 0;
		notes.push_back(n);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		if (w >= 50) check("pready wait", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following call never re-drives psel in the same step
		@(posedge clk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, '{"write", 32'h0, 32'h0, 1'b0});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
		apb(a, 1'b0, 32'h0, '{nm, e, m, 1'b0});
	endtask : rd
	task waitGain(input int tgt, input int lim);
		cyc = 0;
		while (gainCode !== GAIN_W'(tgt) && cyc < lim) begin
			@(posedge clk);
			cyc++;
		end
		check("gain reached", 32'(gainCode), 32'(tgt));
	endtask : waitGain
	task hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	//////////////////////////////////////////////////////////////////////////
	// Answer watcher takes the oldest note per completed transfer
	always @(posedge clk) begin
		if (nrst === 1'b1 && pready === 1'b1) begin
			if (notes.size() == 0) begin
				check("spare answer", 32'h1, 32'h0);
			end else begin
				cur = notes.pop_front();
				check(cur.nm, prdata & cur.mask, cur.val & cur.mask);
				check({cur.nm, " error"}, 32'(pslverr), 32'(cur.err));
			end
		end
	end
	always @(posedge clk) begin
		if (stepWatch && gainCode !== prevGain) begin
			check("step size", 32'(gainCode > prevGain ? gainCode - prevGain
				: prevGain - gainCode), 32'h1);
		end
		prevGain <= gainCode;
	end
	initial begin
		// Tests need about 50k cycles; margin for slow rate steps
		hold(80000);
		fails++;
		wrap_up();
	end
	//////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, nrst, psel, penable, pwrite, stepWatch} = '0;
		{paddr, inLevel, pwdata, fails, checkCount} = '0;
		void'($urandom(69));
		hold(5);
		nrst <= 1'b1;
		@(posedge clk);
		rd(OFS_PWR_MODE, 32'(PWR_MODE_RST), '1, "mode reset");
		rd(OFS_FAST_RATE, 32'(FAST_RATE_RST), '1, "fast reset");
		rd(OFS_SLOW_RATE, 32'(SLOW_RATE_RST), '1, "slow reset");
		rd(OFS_GAIN_SET, 32'(GAIN_SET_RST), '1, "gain reset");
		rd(OFS_STATUS, 32'h0, 32'h7F, "gain at reset");
		apb(8'h14, 1'b0, 32'h0, '{"unmapped", 32'h0, '1, 1'b1});
		apb(8'h14, 1'b1, $urandom, '{"unmapped write", 32'h0, 32'h0, 1'b1});
		$display("test reset done");
		wr(OFS_PWR_MODE, 32'hFFFFFFFF);
		rd(OFS_PWR_MODE, 32'h1C, '1, "mode bits");
		t = $urandom;
		wr(OFS_FAST_RATE, t);
		rd(OFS_FAST_RATE, t & 32'h77, '1, "fast rate");
		wr(OFS_GAIN_SET, 32'h7F);
		rd(OFS_GAIN_SET, 32'h52, '1, "gain clamp");
		t = $urandom % 83;
		wr(OFS_GAIN_SET, t);
		hold(3);
		rd(OFS_STATUS, t, 32'h7F, "immediate gain");
		wr(OFS_GAIN_SET, 32'h14);
		hold(3);
		rd(OFS_STATUS, 32'h14, 32'h7F, "immediate gain");
		$display("test registers done");
		// Fixed stepped: 40 steps up then 10 down, about 312.5 cycles per step
		wr(OFS_PWR_MODE, 32'h08);
		stepWatch <= 1'b1;
		wr(OFS_GAIN_SET, 32'h3C);
		waitGain(60, 14000);
		check("step time up", 32'(cyc >= 39 * 312 && cyc <= 40 * 313 + 20), 32'h1);
		wr(OFS_GAIN_SET, 32'h32);
		waitGain(50, 4000);
		check("step time down", 32'(cyc >= 9 * 312 && cyc <= 10 * 313 + 20), 32'h1);
		$display("test fixed stepped done");
		// Single rate: loud input settles at 30, quiet input needs the hold time
		wr(OFS_FAST_RATE, 32'h00);
		wr(OFS_GAIN_SET, 32'hA8);
		wr(OFS_PWR_MODE, 32'h04);
		inLevel <= 8'd70;
		waitGain(30, 8000);
		hold(500);
		rd(OFS_GAIN_SET, 32'd30, 32'h7F, "applied gain read");
		inLevel <= 8'd40;
		hold(1900);
		check("long hold", 32'(gainCode), 32'd30);
		inLevel <= 8'd66;
		hold(20);
		inLevel <= 8'd40;
		hold(1900);
		check("hold restart", 32'(gainCode), 32'd30);
		waitGain(40, 6000);
		hold(1500);
		check("gain ceiling", 32'(gainCode), 32'd40);
		wr(OFS_PWR_MODE, 32'h14);
		inLevel <= 8'd70;
		waitGain(30, 8000);
		inLevel <= 8'd40;
		hold(950);
		check("short hold", 32'(gainCode), 32'd30);
		hold(450);
		check("short hold rise", 32'(gainCode === 7'd31 || gainCode === 7'd32), 32'h1);
		waitGain(40, 4000);
		$display("test single rate done");
		// Dual rate: slow counter at half the fast rate holds back the release
		wr(OFS_SLOW_RATE, 32'h11);
		wr(OFS_PWR_MODE, 32'h10);
		inLevel <= 8'd70;
		waitGain(30, 5000);
		check("dual attack fast", 32'(cyc < 4000), 32'h1);
		inLevel <= 8'd40;
		waitGain(40, 12000);
		check("dual release slow", 32'(cyc > 5000), 32'h1);
		$display("test dual rate done");
		hold(5);
		wrap_up();
	end
endmodule : testbench
